// File: hw/rbc_pkg.sv
// rbc_pkg: register map, field positions, reset values and timing counts
// for the bit coding and preamble detect block.
// assumes an apb slave with 32-bit data and byte addresses.
`default_nettype none
package rbc_pkg;
  // byte addresses
  localparam logic [7:0] ADDR_OPFUNC2  = 8'h80;
  localparam logic [7:0] ADDR_CODING   = 8'h70;
  localparam logic [7:0] ADDR_PREA_HI  = 8'h33;
  localparam logic [7:0] ADDR_PREA_LO  = 8'h34;
  localparam logic [7:0] ADDR_PREA_DET = 8'h35;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h06;
  localparam logic [7:0] ADDR_CMD      = 8'h07;
  localparam logic [7:0] ADDR_TXCTL    = 8'h3e;
  // reset values
  localparam logic [7:0] RST_OPFUNC2   = 8'h00;
  localparam logic [7:0] RST_PREA_HI   = 8'h00;
  localparam logic [7:0] RST_PREA_LO   = 8'h07;
  localparam logic [7:0] RST_PREA_DET  = 8'h20;
  localparam logic [7:0] RST_CODING    = 8'h00;
  localparam logic [7:0] RST_IRQ_EN    = 8'h00;
  localparam logic [7:0] RST_TXCTL     = 8'h08;
  // field positions
  localparam int OPF_AUTOTX  = 3;
  localparam int COD_WHITE   = 0;
  localparam int COD_MANCH   = 1;
  localparam int CMD_RXON    = 0;
  localparam int CMD_TXON    = 1;
  localparam int CMD_LOAD    = 2;
  localparam int ST_DET      = 1;
  localparam int ST_INV      = 0;
  localparam int ST_SYNC     = 2;
  localparam int ST_TXBUSY   = 3;
  // timing and pattern sizes
  localparam int SETTLE_BITS = 16;
  localparam int NIBBLE_BITS = 4;
  localparam logic [8:0] PN9_SEED = 9'h1ff;
  localparam int SYNC_BITS   = 16;
  localparam logic [15:0] SYNC_WORD = 16'h2dd4;
  typedef enum logic [2:0] {
    RBC_IDLE  = 3'b000,
    RBC_PREA  = 3'b001,
    RBC_SYNC  = 3'b010,
    RBC_PAY   = 3'b011,
    RBC_DONE  = 3'b100
  } rbc_tx_t;
endpackage : rbc_pkg
`default_nettype wire

// File: hw/rbc_top.sv
// rbc_top: whitening, manchester coding, preamble detect, invalid preamble
// detect, retransmit and auto transmit, with apb registers.
// assumes one clock; bit_tick marks each bit period (two half periods under manchester, one otherwise).
//
// How it works
// - payload tx bits are xored with the pn9 output when whitening on
// - pn9 reloads to its seed at the first payload bit
// - receiver xors payload bits with identically seeded pn9
// - manchester sends two symbols per bit, preamble included
// - preamble length is nine-bit field, 1 to 512 bytes
// - threshold is five bits in nibbles; detect after that many bits
// - detector searches the received stream until sync is found, then not again until receive is re-enabled
// - detect without following sync is dropped and search resumes
// - detect drives an output pin and a status flag
// - pattern error raises invalid flag and a maskable interrupt
// - invalid flag held low 16 bit periods after receive enable
// - transmit-on with no new load resends the last packet
// - only packets fitting the fifo can be resent
// - autotx starts transmit when fifo reaches almost full
// - autotx returns to idle after the packet is sent
`default_nettype none
module rbc_top #(
  parameter int PKT_BITS  = 64,
  parameter int FIFO_BITS = 512
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        half_tick,
  input  wire logic        rx_sym,
  input  wire logic        fifo_almost_full,
  input  wire logic        tx_data_bit,
  input  wire logic [8:0]  pkt_len_bits,
  output logic             tx_sym,
  output logic             tx_active,
  output logic             tx_payload_req,
  output logic             rx_data_bit,
  output logic             rx_data_valid,
  output logic             preamble_det_pin,
  output logic             irq
);
  // registers
  logic [7:0] opfunc2_q, coding_q, prea_hi_q, prea_lo_q, prea_det_q;
  logic [7:0] irq_en_q;
  logic [3:0] status_q;
  logic       rx_en_q, new_pkt_q, fits_q;
  logic       wr, rd, hit;
  logic [7:0] rdv;
  logic       txon_cmd, load_cmd;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;

  // register writes; a command word yields single-cycle strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opfunc2_q  <= rbc_pkg::RST_OPFUNC2;
      coding_q   <= rbc_pkg::RST_CODING;
      prea_hi_q  <= rbc_pkg::RST_PREA_HI;
      prea_lo_q  <= rbc_pkg::RST_PREA_LO;
      prea_det_q <= rbc_pkg::RST_PREA_DET;
      irq_en_q   <= rbc_pkg::RST_IRQ_EN;
      rx_en_q    <= 1'b0;
    end else if (wr) begin
      case (paddr)
        rbc_pkg::ADDR_OPFUNC2:  opfunc2_q  <= pwdata[7:0];
        rbc_pkg::ADDR_CODING:   coding_q   <= pwdata[7:0];
        rbc_pkg::ADDR_PREA_HI:  prea_hi_q  <= pwdata[7:0];
        rbc_pkg::ADDR_PREA_LO:  prea_lo_q  <= pwdata[7:0];
        rbc_pkg::ADDR_PREA_DET: prea_det_q <= pwdata[7:0];
        rbc_pkg::ADDR_IRQ_EN:   irq_en_q   <= pwdata[7:0];
        rbc_pkg::ADDR_CMD:      rx_en_q    <= pwdata[rbc_pkg::CMD_RXON];
        default: ;
      endcase
    end
  end

  assign txon_cmd = wr && paddr == rbc_pkg::ADDR_CMD
                    && pwdata[rbc_pkg::CMD_TXON];
  assign load_cmd = wr && paddr == rbc_pkg::ADDR_CMD
                    && pwdata[rbc_pkg::CMD_LOAD];

  // read mux; unmapped addresses answer with slverr
  // the command register reads back only the receive enable level;
  // its strobes leave nothing behind to read
  always_comb begin
    hit = 1'b1;
    rdv = 8'h00;
    case (paddr)
      rbc_pkg::ADDR_OPFUNC2:  rdv = opfunc2_q;
      rbc_pkg::ADDR_CODING:   rdv = coding_q;
      rbc_pkg::ADDR_PREA_HI:  rdv = prea_hi_q;
      rbc_pkg::ADDR_PREA_LO:  rdv = prea_lo_q;
      rbc_pkg::ADDR_PREA_DET: rdv = {prea_det_q[7:3], 3'h0};
      rbc_pkg::ADDR_STATUS:   rdv = {4'h0, status_q};
      rbc_pkg::ADDR_IRQ_EN:   rdv = irq_en_q;
      rbc_pkg::ADDR_CMD:      rdv = {7'h00, rx_en_q};
      default:                hit = 1'b0;
    endcase
  end

  // zero-wait slave: answer in the first access cycle
  // writes land at the edge where pready is seen high, not at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata  <= (psel && !penable && !pwrite) ? {24'h0, rdv} : prdata;
    end
  end

  // ---------------- transmit ----------------
  rbc_pkg::rbc_tx_t st_q;
  logic [8:0]  pn_tx_q, pn_rx_q;
  logic [11:0] bit_cnt_q;
  logic        phase_q, bit_tick;
  logic        cur_bit, auto_q;
  logic [11:0] prea_bits;

  // length field holds bytes minus one; 12 bits cover 512 bytes
  assign prea_bits = {prea_hi_q[0], prea_lo_q, 3'h0} + 12'd8;
  assign bit_tick  = half_tick &&
                     (phase_q || !coding_q[rbc_pkg::COD_MANCH]);

  // half-symbol phase; manchester spends two halves per bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) phase_q <= 1'b0;
    else if (half_tick) phase_q <= !phase_q;
  end

  // packet bookkeeping: a load marks new data, a send consumes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      new_pkt_q <= 1'b0;
      fits_q    <= 1'b0;
    end else if (load_cmd) begin
      new_pkt_q <= 1'b1;
      fits_q    <= 32'(pkt_len_bits) <= FIFO_BITS;
    end else if (st_q == rbc_pkg::RBC_DONE) begin
      new_pkt_q <= 1'b0;
    end
  end

  // tx sequencer: preamble, sync, payload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q      <= rbc_pkg::RBC_IDLE;
      bit_cnt_q <= 12'h000;
      auto_q    <= 1'b0;
    end else begin
      case (st_q)
        rbc_pkg::RBC_IDLE: begin
          bit_cnt_q <= 12'h000;
          if (txon_cmd && (new_pkt_q || fits_q)) begin
            st_q   <= rbc_pkg::RBC_PREA;
            auto_q <= 1'b0;
          end else if (opfunc2_q[rbc_pkg::OPF_AUTOTX] && fifo_almost_full
                       && new_pkt_q) begin
            st_q   <= rbc_pkg::RBC_PREA;
            auto_q <= 1'b1;
          end
        end
        rbc_pkg::RBC_PREA: if (bit_tick) begin
          if (bit_cnt_q == prea_bits - 12'd1) begin
            st_q <= rbc_pkg::RBC_SYNC;
            bit_cnt_q <= 12'h000;
          end else bit_cnt_q <= bit_cnt_q + 12'd1;
        end
        rbc_pkg::RBC_SYNC: if (bit_tick) begin
          if (bit_cnt_q == 12'(rbc_pkg::SYNC_BITS - 1)) begin
            st_q <= rbc_pkg::RBC_PAY;
            bit_cnt_q <= 12'h000;
          end else bit_cnt_q <= bit_cnt_q + 12'd1;
        end
        rbc_pkg::RBC_PAY: if (bit_tick) begin
          if (bit_cnt_q == {3'h0, pkt_len_bits} - 12'd1)
            st_q <= rbc_pkg::RBC_DONE;
          else bit_cnt_q <= bit_cnt_q + 12'd1;
        end
        rbc_pkg::RBC_DONE: st_q <= rbc_pkg::RBC_IDLE;
        default: st_q <= rbc_pkg::RBC_IDLE;
      endcase
    end
  end

  // tx pn9: seeded on payload entry so header bits stay plain
  // fibonacci form: newest bit is the xor of the bits 9 and 5 back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pn_tx_q <= rbc_pkg::PN9_SEED;
    else if (st_q != rbc_pkg::RBC_PAY) pn_tx_q <= rbc_pkg::PN9_SEED;
    else if (bit_tick)
      pn_tx_q <= {pn_tx_q[7:0], pn_tx_q[8] ^ pn_tx_q[4]};
  end

  // bit value on air before manchester
  always_comb begin
    case (st_q)
      rbc_pkg::RBC_PREA: cur_bit = !bit_cnt_q[0];
      rbc_pkg::RBC_SYNC: cur_bit = rbc_pkg::SYNC_WORD[
                           4'(rbc_pkg::SYNC_BITS - 1) - bit_cnt_q[3:0]];
      rbc_pkg::RBC_PAY:  cur_bit = tx_data_bit ^
        (coding_q[rbc_pkg::COD_WHITE] & pn_tx_q[8]);
      default:           cur_bit = 1'b0;
    endcase
  end

  // symbol output: manchester gives bit then its inverse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sym         <= 1'b0;
      tx_active      <= 1'b0;
      tx_payload_req <= 1'b0;
    end else begin
      tx_sym <= (coding_q[rbc_pkg::COD_MANCH] && phase_q) ?
                !cur_bit : cur_bit;
      tx_active      <= st_q != rbc_pkg::RBC_IDLE;
      tx_payload_req <= st_q == rbc_pkg::RBC_PAY && bit_tick;
    end
  end

  // ---------------- receive ----------------
  logic        first_half_q, rx_bit, rx_tick;
  logic        prev_q;
  logic [7:0]  run_q;
  logic [4:0]  settle_q;
  logic [15:0] sync_sh_q;
  logic [5:0]  wait_q;
  logic        det_q, in_pay_q;
  logic [7:0]  thr_bits;

  // a zero threshold never detects; software must set one nibble or more
  assign thr_bits = {prea_det_q[7:3], 3'h0} >> 1; // nibbles to bits
  // decoder takes polarity of first half as the bit
  assign rx_bit  = coding_q[rbc_pkg::COD_MANCH] ? first_half_q : rx_sym;
  assign rx_tick = bit_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) first_half_q <= 1'b0;
    else if (half_tick && !phase_q) first_half_q <= rx_sym;
  end

  // alternating-run counter searches without pause
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
      run_q  <= 8'h00;
    end else if (!rx_en_q) begin
      run_q <= 8'h00;
    end else if (rx_tick) begin
      prev_q <= rx_bit;
      if (rx_bit != prev_q) run_q <= (run_q == 8'hff) ? run_q
                                     : run_q + 8'd1;
      else run_q <= 8'h00;
    end
  end

  // detect, then sync search with a timeout back to preamble search
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_q     <= 1'b0;
      in_pay_q  <= 1'b0;
      wait_q    <= 6'h00;
      sync_sh_q <= 16'h0000;
    end else if (!rx_en_q) begin
      det_q    <= 1'b0;
      in_pay_q <= 1'b0;
    end else if (rx_tick) begin
      sync_sh_q <= {sync_sh_q[14:0], rx_bit};
      if (!det_q && !in_pay_q && run_q + 8'd1 >= thr_bits
          && thr_bits != 8'h00) begin
        det_q  <= 1'b1;
        wait_q <= 6'h00;
      end else if (det_q) begin
        if ({sync_sh_q[14:0], rx_bit} == rbc_pkg::SYNC_WORD) begin
          det_q    <= 1'b0;
          in_pay_q <= 1'b1;
        end else if (wait_q == 6'h3f) det_q <= 1'b0;
        else wait_q <= wait_q + 6'd1;
      end
    end
  end

  // invalid preamble suppressed during receiver settling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) settle_q <= 5'h00;
    else if (!rx_en_q) settle_q <= 5'h00;
    else if (rx_tick && settle_q != 5'(rbc_pkg::SETTLE_BITS))
      settle_q <= settle_q + 5'd1;
  end

  // rx pn9 dewhitening, seeded until payload starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pn_rx_q <= rbc_pkg::PN9_SEED;
    else if (!in_pay_q) pn_rx_q <= rbc_pkg::PN9_SEED;
    else if (rx_tick)
      pn_rx_q <= {pn_rx_q[7:0], pn_rx_q[8] ^ pn_rx_q[4]};
  end

  // status flags: set wins over clear on status read
  // a repeated bit breaks the pattern, so a quiet line with no preamble
  // at all is reported invalid once settling is over; detect and
  // payload phases mask it, since sync and data bits repeat freely
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q         <= 4'h0;
      preamble_det_pin <= 1'b0;
      rx_data_bit      <= 1'b0;
      rx_data_valid    <= 1'b0;
      irq              <= 1'b0;
    end else begin
      status_q[rbc_pkg::ST_DET] <= det_q ||
        (status_q[rbc_pkg::ST_DET] && !(rd && paddr == rbc_pkg::ADDR_STATUS));
      status_q[rbc_pkg::ST_INV] <= (rx_tick && rx_en_q && !det_q
        && !in_pay_q && settle_q == 5'(rbc_pkg::SETTLE_BITS)
        && rx_bit == prev_q)
        || (status_q[rbc_pkg::ST_INV]
            && !(rd && paddr == rbc_pkg::ADDR_STATUS));
      status_q[rbc_pkg::ST_SYNC]   <= in_pay_q;
      status_q[rbc_pkg::ST_TXBUSY] <= st_q != rbc_pkg::RBC_IDLE;
      preamble_det_pin <= det_q;
      rx_data_valid    <= in_pay_q && rx_tick;
      rx_data_bit      <= rx_bit ^
        (coding_q[rbc_pkg::COD_WHITE] & pn_rx_q[8]);
      irq <= |(status_q[1:0] & irq_en_q[1:0]);
    end
  end
endmodule : rbc_top
`default_nettype wire

// File: testbench/radio_bit_coding_preamble_detect_test.sv
// bench top: apb register tests, receive detect and transmit runs.
// assumes bit rate of one half_tick every four pclk, manchester off except in the last resend.
`default_nettype none
module radio_bit_coding_preamble_detect_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic half_tick = 0, fifo_af = 0, go = 0, se;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, rx_sym, tx_active, tx_req, rx_bit, rx_v, det, irq;
  logic        tx_sym;
  logic [1:0]  tick_q = 2'h0;
  logic [7:0]  ra [7] = '{rbc_pkg::ADDR_OPFUNC2, rbc_pkg::ADDR_PREA_HI,
    rbc_pkg::ADDR_PREA_LO, rbc_pkg::ADDR_PREA_DET, rbc_pkg::ADDR_CODING,
    rbc_pkg::ADDR_IRQ_EN, rbc_pkg::ADDR_CMD};
  logic [7:0]  rv [7] = '{rbc_pkg::RST_OPFUNC2, rbc_pkg::RST_PREA_HI,
    rbc_pkg::RST_PREA_LO, rbc_pkg::RST_PREA_DET, rbc_pkg::RST_CODING,
    rbc_pkg::RST_IRQ_EN, 8'h00}; // command: receive enable off at reset
  int err_total = 0, total_checks = 0, n, cnt;
  always #10 pclk = ~pclk;
  // bit strobe every fourth clock keeps test times short
  always @(posedge pclk) begin
    tick_q    <= tick_q + 2'h1;
    half_tick <= (tick_q == 2'h3);
  end
  rbc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .half_tick(half_tick), .rx_sym(rx_sym), .fifo_almost_full(fifo_af),
    .tx_data_bit(1'b0), .pkt_len_bits(9'h010), .tx_sym(tx_sym),
    .tx_active(tx_active), .tx_payload_req(tx_req), .rx_data_bit(rx_bit),
    .rx_data_valid(rx_v), .preamble_det_pin(det), .irq(irq));
  rbc_remote_model u_remote (.pclk(pclk), .presetn(presetn),
    .half_tick(half_tick), .go(go), .rx_sym(rx_sym));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      err_total++;
      report_and_stop();
    end
  endtask : tmo
  // request held from setup until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    tmo(n, 20);
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // waits for a transmit run; counts payload bits pulled and the ones
  // on the line at each pull (second half symbol under manchester)
  task automatic tx_run(input int ones);
    int hi;
    hi = 0;
    for (n = 0; n < 40 && tx_active !== 1'b1; n++) @(posedge pclk);
    tmo(n, 40);
    fifo_af <= 0;
    cnt = 0;
    for (n = 0; n < 1500 && tx_active !== 1'b0; n++) begin
      @(posedge pclk);
      if (tx_req === 1'b1) cnt++;
      if (tx_req === 1'b1 && tx_sym === 1'b1) hi++;
    end
    tmo(n, 1500);
    chk(cnt, 16);
    chk(hi, ones);
  endtask : tx_run
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    foreach (ra[i]) begin
      apb(0, ra[i], 32'h0);
      chk(rd, {24'h0, rv[i]});
    end
    $display("test reset values done");
    apb(1, rbc_pkg::ADDR_OPFUNC2, 32'h08);
    apb(0, rbc_pkg::ADDR_OPFUNC2, 32'h0);
    chk(rd, 32'h08);
    apb(1, 8'h10, 32'hff);
    chk(se, 1'b1);
    apb(0, 8'h10, 32'h0);
    chk({rd[31:1], se}, 32'h1);
    apb(1, rbc_pkg::ADDR_OPFUNC2, 32'h0);
    $display("test register access done");
    // steady line is a broken pattern, but not inside the settle time
    // 20-bit threshold, since the receiver listens long before the packet
    apb(1, rbc_pkg::ADDR_PREA_DET, 32'h28);
    apb(1, rbc_pkg::ADDR_CODING, 32'h01);
    apb(1, rbc_pkg::ADDR_IRQ_EN, 32'h01);
    apb(1, rbc_pkg::ADDR_CMD, 32'h01);
    cnt = 0;
    repeat (60) begin
      @(posedge pclk);
      if (irq !== 1'b0) cnt++;
    end
    chk(cnt, 0);
    for (n = 0; n < 400 && irq !== 1'b1; n++) @(posedge pclk);
    tmo(n, 400);
    chk(irq, 1'b1);
    apb(1, rbc_pkg::ADDR_IRQ_EN, 32'h0);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    apb(0, rbc_pkg::ADDR_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h1);
    $display("test invalid preamble done");
    go <= 1;
    @(posedge pclk);
    go <= 0;
    for (n = 0; n < 600 && det !== 1'b1; n++) @(posedge pclk);
    tmo(n, 600);
    chk(det, 1'b1);
    apb(0, rbc_pkg::ADDR_STATUS, 32'h0);
    chk(rd & 32'h2, 32'h2);
    cnt = 0;
    for (n = 0; n < 400; n++) begin
      @(posedge pclk);
      if (rx_v === 1'b1 && cnt < 16) begin
        cnt++;
        chk(rx_bit, 1'b0);
      end
    end
    chk(cnt, 16);
    apb(1, rbc_pkg::ADDR_CMD, 32'h0);
    $display("test detect and dewhiten done");
    apb(1, rbc_pkg::ADDR_CMD, 32'h04);
    apb(1, rbc_pkg::ADDR_OPFUNC2, 32'h08);
    fifo_af <= 1;
    // whitened zero payload: 11 ones in the first 16 pn9 bits
    tx_run(11);
    apb(1, rbc_pkg::ADDR_OPFUNC2, 32'h0);
    apb(1, rbc_pkg::ADDR_CMD, 32'h02);
    tx_run(11);
    // manchester resend, whitening off: each pulled zero bit shows a
    // high second half; the bit strobe stands for a rate within limit
    apb(1, rbc_pkg::ADDR_CODING, 32'h02);
    apb(1, rbc_pkg::ADDR_CMD, 32'h02);
    tx_run(16);
    $display("test auto transmit and resend done");
    report_and_stop();
  end
endmodule : radio_bit_coding_preamble_detect_test
`default_nettype wire

// File: testbench/rbc_remote_model.sv
// rbc_remote_model: far transmitter, one bit per half_tick, no manchester.
// sends 32 preamble bits, the sync word, then 16 whitened zero bits.
`default_nettype none
module rbc_remote_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic half_tick,
  input wire logic go,
  output logic     rx_sym
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] pos_q;
  logic [8:0] pn_q;
  logic       run_q;
  // idle line shows the inverse of the last bit, a steady noise level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q  <= 1'b0;
      pos_q  <= 7'h00;
      pn_q   <= rbc_pkg::PN9_SEED;
      rx_sym <= 1'b0;
    end else if (go) begin
      run_q <= 1'b1;
      pos_q <= 7'h00;
      pn_q  <= rbc_pkg::PN9_SEED;
    end else if (run_q && half_tick) begin
      pos_q <= pos_q + 7'h01;
      if (pos_q < 7'd32) begin
        rx_sym <= ~pos_q[0];
      end else if (pos_q < 7'd48) begin
        rx_sym <= rbc_pkg::SYNC_WORD[~pos_q[3:0]];
      end else if (pos_q < 7'd64) begin
        rx_sym <= pn_q[0];
        pn_q   <= {pn_q[0] ^ pn_q[4], pn_q[8:1]};
      end else begin
        run_q  <= 1'b0;
        rx_sym <= ~rx_sym;
      end
    end
  end
endmodule : rbc_remote_model
`default_nettype wire

// File: testbench/rbc_top_sva.sv
// rbc_top_sva: port-level checks for rbc_top.
// assumes apb with zero wait states and a single pclk domain.
`default_nettype none
module rbc_top_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        tx_active,
  input wire logic        tx_payload_req,
  input wire logic        rx_data_valid,
  input wire logic        preamble_det_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // apb answers in the first access cycle and never unasked
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  no_spurious_a: assert property (!(psel && !penable) |=> !pready)
    else $error("ready without setup");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  err_rdata_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  mapped_ok_a: assert property (psel && !penable &&
    paddr == rbc_pkg::ADDR_OPFUNC2 |=> !pslverr)
    else $error("mapped register refused");
  // preamble must lead, so no payload bit is pulled right at start
  preamble_first_a: assert property ($rose(tx_active) |-> !tx_payload_req[*8])
    else $error("payload before preamble");
  payreq_idle_a: assert property (tx_payload_req |-> tx_active)
    else $error("payload request while idle");
  rx_pulse_a: assert property (rx_data_valid |=> !rx_data_valid)
    else $error("rx valid longer than a pulse");
  cover property ($rose(preamble_det_pin));
  cover property ($fell(tx_active));
  cover property (pslverr);
endmodule : rbc_top_sva
bind rbc_top rbc_top_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tx_active(tx_active),
  .tx_payload_req(tx_payload_req), .rx_data_valid(rx_data_valid),
  .preamble_det_pin(preamble_det_pin));
`default_nettype wire
